// file: src/twc_ctrl.sv
// Two-wire bus controller: master sequencer, slave responder, register port
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module twc_ctrl
	import twc_pkg::*;
#(
	parameter int BRG_W = 9
)(
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	// Register port
	input  wire logic [ADDR_W-1:0] BUS_ADDR,
	input  wire logic [15:0]       BUS_WDATA,
	input  wire logic              BUS_WR,
	input  wire logic              BUS_RD,
	output      logic [15:0]       BUS_RDATA,
	// Device power state
	input  wire logic              IDLE_MODE,
	// Clock line
	input  wire logic              SCL_I,
	output      logic              SCL_O,
	output      logic              SCL_OE_N,
	// Data line
	input  wire logic              SDA_I,
	output      logic              SDA_O,
	output      logic              SDA_OE_N,
	// Pad control
	output      logic              PINS_OWNED,
	output      logic              SLEW_DISABLE,
	output      logic              ALT_THRESHOLD,
	// Events
	output      logic              MASTER_EVENT,
	output      logic              SLAVE_EVENT
);
	// Reload below the legal minimum cannot be held by a narrower counter
	generate
		if (BRG_W < BRG_MIN || BRG_W > 16) begin : g_chk
			$error("BRG_W must lie between 2 and 16");
		end
	endgenerate

	twc_con_t        con_q, con_d, cw;
	twc_stat_t       st_q, st_d, sw;
	twc_mst_t        mst_q, mst_d;
	twc_slv_t        sst_q, sst_d;
	twc_kind_t       sk_q, sk_d;
	twc_drive_t      mdrv, sdrv;
	logic [BRG_W-1:0] brg_q, brg_d, hcnt_q, hcnt_d;
	logic [9:0]      msk_q, msk_d, own_q, own_d, mask;
	logic [7:0]      trn_q, trn_d, rcv_q, rcv_d, msh_q, msh_d, ssh_q, ssh_d;
	logic [15:0]     rdat_d;
	logic [1:0]      mph_q, mph_d;
	logic [3:0]      mbit_q, mbit_d, sbit_q, sbit_d;
	logic            mown_q, mown_d, mev_d, sev_d, acc, rel;
	logic            scl_oe_n_d, sda_oe_n_d;
	logic [2:0]      scl_sy, sda_sy;
	logic            run, tick, hold, busy, rise, fall, sta_det, sto_det;
	logic            hit7, hitu, hitl, gcall;

	// Two-stage synchronisers, third stage only keeps the previous level
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			scl_sy <= LINE_IDLE;
			sda_sy <= LINE_IDLE;
		end else begin
			scl_sy <= {scl_sy[1:0], SCL_I};
			sda_sy <= {sda_sy[1:0], SDA_I};
		end
	end

	// Line events seen on synchronised levels
	assign rise    = scl_sy[1] & ~scl_sy[2];
	assign fall    = ~scl_sy[1] & scl_sy[2];
	assign sta_det = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
	assign sto_det = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];
	assign run     = con_q.module_enable & ~(con_q.stop_in_idle & IDLE_MODE); // [R07]
	assign busy    = (mst_q != M_IDLE) | st_q.transmit_full_flag;

	// Released clock still low means another party stretches; the timer waits
	assign hold = ~mdrv.scl_low & ~scl_sy[1];
	assign tick = (hcnt_q == '0) & ~hold; // [R24]

	// Address compare, masked bits are don't-care unless all-address mode is on
	assign mask  = con_q.all_address_ack_enable ? '0 : msk_q; // [R04]
	assign hit7  = (((ssh_q[7:1] ^ own_q[6:0]) & ~mask[6:0]) == '0) && (ssh_q != GEN_CALL); // [R03]
	assign hitu  = (ssh_q[7:3] == TEN_PREFIX) && (((ssh_q[2:1] ^ own_q[9:8]) & ~mask[9:8]) == '0);
	assign hitl  = ((ssh_q ^ own_q[7:0]) & ~mask[7:0]) == '0; // [R03]
	assign gcall = con_q.general_call_enable && (ssh_q == GEN_CALL); // [R14]

	// Master line drive per state and half-period
	always_comb begin
		mdrv = '0;
		case (mst_q)
			M_IDLE: begin
				mdrv.scl_low = mown_q;
			end
			M_START: begin // [R20]
				mdrv.sda_low = 1'b1;
				mdrv.scl_low = (mph_q != PH0);
			end
			M_RSTART: begin // [R19]
				mdrv.scl_low = (mph_q == PH0) | (mph_q == PH3);
				mdrv.sda_low = mph_q[1];
			end
			M_STOP: begin // [R18]
				mdrv.sda_low = (mph_q != PH2);
				mdrv.scl_low = (mph_q == PH0);
			end
			M_TX: begin
				mdrv.scl_low = (mph_q == PH0);
				mdrv.sda_low = (mbit_q != BYTE_BITS) & ~msh_q[7];
			end
			M_RX: begin
				mdrv.scl_low = (mph_q == PH0);
			end
			M_ACK: begin
				mdrv.scl_low = (mph_q == PH0);
				mdrv.sda_low = ~con_q.ack_data_value; // [R15]
			end
			default: begin
				mdrv = '0;
			end
		endcase
	end

	// Slave line drive: acknowledge, transmit bits and clock stretch
	always_comb begin
		sdrv.sda_low = (sst_q == SL_ACKO) | ((sst_q == SL_SEND) & ~trn_q[~sbit_q[2:0]]);
		sdrv.scl_low = (sst_q != SL_IDLE) & ~con_q.clock_release; // [R08]
	end

	// Next values of all control, status and sequencer state
	always_comb begin
		con_d  = con_q;
		st_d   = st_q;
		mst_d  = mst_q;
		sst_d  = sst_q;
		sk_d   = sk_q;
		brg_d  = brg_q;
		msk_d  = msk_q;
		own_d  = own_q;
		trn_d  = trn_q;
		rcv_d  = rcv_q;
		msh_d  = msh_q;
		ssh_d  = ssh_q;
		mph_d  = mph_q;
		mbit_d = mbit_q;
		sbit_d = sbit_q;
		mown_d = mown_q;
		mev_d  = 1'b0;
		sev_d  = 1'b0;
		acc    = 1'b0;
		rel    = 1'b0;
		rdat_d = '0;
		cw     = twc_con_t'(BUS_WDATA);
		sw     = twc_stat_t'(BUS_WDATA);

		// Reads and flag clears come first so a same-cycle hardware set wins
		if (BUS_RD) begin
			if (BUS_ADDR == REG_CON) begin
				rdat_d = con_q;
			end else if (BUS_ADDR == REG_STAT) begin
				rdat_d = st_q;
			end else if (BUS_ADDR == REG_BRG) begin
				rdat_d = 16'(brg_q);
			end else if (BUS_ADDR == REG_MSK) begin
				rdat_d = {6'h00, msk_q};
			end else if (BUS_ADDR == REG_OWN) begin
				rdat_d = {6'h00, own_q};
			end else if (BUS_ADDR == REG_TRN) begin
				rdat_d = {8'h00, trn_q};
			end else if (BUS_ADDR == REG_RCV) begin
				rdat_d = {8'h00, rcv_q};
				st_d.receive_full_flag = 1'b0; // [R23]
			end
		end
		if (BUS_WR) begin
			if (BUS_ADDR == REG_STAT) begin
				st_d.write_collision_flag = st_q.write_collision_flag & sw.write_collision_flag;
				st_d.overflow_flag        = st_q.overflow_flag & sw.overflow_flag;
				st_d.bus_collision        = st_q.bus_collision & sw.bus_collision;
			end else if (BUS_ADDR == REG_BRG) begin
				brg_d = BUS_WDATA[BRG_W-1:0]; // [R02]
			end else if (BUS_ADDR == REG_MSK) begin
				msk_d = BUS_WDATA[9:0];
			end else if (BUS_ADDR == REG_OWN) begin
				own_d = BUS_WDATA[9:0];
			end
		end

		// Half-period timer reloads on each tick and freezes while stretched
		if (mst_q == M_IDLE || tick) begin
			hcnt_d = brg_q; // [R24] [R01]
		end else if (hold) begin
			hcnt_d = hcnt_q;
		end else begin
			hcnt_d = hcnt_q - 1'b1;
		end

		// Master sequencer; one bit set at a time is served in fixed priority
		case (mst_q)
			M_IDLE: begin
				mph_d  = PH0;
				mbit_d = '0;
				if (con_q.start_sequence_start && !mown_q) begin
					mst_d = M_START;
				end else if (con_q.restart_sequence_start && mown_q) begin
					mst_d = M_RSTART;
				end else if (con_q.stop_sequence_start && mown_q) begin
					mst_d = M_STOP;
				end else if (con_q.master_receive_start && mown_q) begin
					mst_d = M_RX;
				end else if (con_q.ack_sequence_start && mown_q) begin
					mst_d = M_ACK;
				end
			end
			M_START: begin
				if (tick && mph_q == PH0) begin
					mph_d = PH1;
				end else if (tick) begin
					con_d.start_sequence_start = 1'b0; // [R20]
					mown_d = 1'b1;
					mev_d  = 1'b1;
					mst_d  = M_IDLE;
				end
			end
			M_RSTART: begin
				if (tick && mph_q != PH3) begin
					mph_d = mph_q + 2'h1;
				end else if (tick) begin
					con_d.restart_sequence_start = 1'b0; // [R19]
					mev_d = 1'b1;
					mst_d = M_IDLE;
				end
			end
			M_STOP: begin
				if (tick && mph_q != PH2) begin
					mph_d = mph_q + 2'h1;
				end else if (tick) begin
					con_d.stop_sequence_start = 1'b0; // [R18]
					mown_d = 1'b0;
					mev_d  = 1'b1;
					mst_d  = M_IDLE;
				end
			end
			M_TX: begin
				if (tick && mph_q == PH0) begin
					mph_d = PH1;
				end else if (tick && mbit_q == BYTE_BITS) begin
					st_d.ack_received_flag  = sda_sy[1]; // [R21]
					st_d.tx_status          = 1'b0;
					st_d.transmit_full_flag = 1'b0;
					mev_d = 1'b1;
					mst_d = M_IDLE;
				end else if (tick) begin
					mph_d  = PH0;
					msh_d  = {msh_q[6:0], 1'b0};
					mbit_d = mbit_q + 4'h1;
				end
			end
			M_RX: begin
				if (tick && mph_q == PH0) begin
					mph_d = PH1;
				end else if (tick) begin
					mph_d  = PH0;
					msh_d  = {msh_q[6:0], sda_sy[1]};
					mbit_d = mbit_q + 4'h1;
					if (mbit_q == LAST_BIT) begin
						if (st_q.receive_full_flag) begin
							st_d.overflow_flag = 1'b1;
						end
						rcv_d = {msh_q[6:0], sda_sy[1]};
						st_d.receive_full_flag = 1'b1; // [R23]
						con_d.master_receive_start = 1'b0; // [R17]
						mev_d = 1'b1;
						mst_d = M_IDLE;
					end
				end
			end
			M_ACK: begin
				if (tick && mph_q == PH0) begin
					mph_d = PH1;
				end else if (tick) begin
					con_d.ack_sequence_start = 1'b0; // [R16]
					mev_d = 1'b1;
					mst_d = M_IDLE;
				end
			end
			default: begin
				mst_d = M_IDLE;
			end
		endcase

		// Slave responder; Stop and Start override any byte in progress
		if (sto_det) begin
			st_d.stop_seen       = 1'b1;
			st_d.start_seen      = 1'b0;
			st_d.gen_call_status = 1'b0;
			st_d.addr10_status   = 1'b0;
			sst_d = SL_IDLE;
		end else if (sta_det && mst_q == M_IDLE && !mown_q) begin
			st_d.start_seen = 1'b1;
			st_d.stop_seen  = 1'b0;
			sst_d  = SL_RECV;
			sk_d   = SK_ADR1;
			sbit_d = '0;
		end else begin
			case (sst_q)
				SL_RECV: begin
					if (rise) begin
						ssh_d  = {ssh_q[6:0], sda_sy[1]};
						sbit_d = sbit_q + 4'h1;
					end else if (fall && sbit_q == BYTE_BITS) begin
						sbit_d = '0;
						sst_d  = SL_IDLE;
						case (sk_q)
							SK_ADR1: begin
								if (con_q.ten_bit_address_select && !mask[0] && !con_q.all_address_ack_enable) begin
									acc  = hitu & (~ssh_q[0] | st_q.addr10_status); // [R12]
									sk_d = ssh_q[0] ? SK_READ : SK_ADR2;
								end else begin
									acc  = hit7 | gcall | con_q.all_address_ack_enable; // [R05] [R12]
									sk_d = ssh_q[0] ? SK_READ : SK_DATA;
									st_d.gen_call_status = gcall; // [R14]
								end
								if (acc) begin
									st_d.read_not_write = ssh_q[0];
									st_d.data_not_addr  = 1'b0;
									sev_d = 1'b1;
									if (ssh_q[0]) begin
										con_d.clock_release = 1'b0; // [R09] [R10]
									end
								end
							end
							SK_ADR2: begin
								acc  = hitl | con_q.all_address_ack_enable; // [R03]
								sk_d = SK_DATA;
								st_d.addr10_status = acc;
								sev_d = acc;
							end
							default: begin
								// A full receive holding register refuses the byte
								acc = ~st_q.receive_full_flag;
								st_d.overflow_flag = st_q.overflow_flag | st_q.receive_full_flag;
								if (acc) begin
									rcv_d = ssh_q;
								end
								st_d.receive_full_flag = 1'b1; // [R23]
								st_d.data_not_addr = 1'b1;
								sev_d = 1'b1;
								if (con_q.stretch_enable) begin
									con_d.clock_release = 1'b0; // [R09] [R11]
								end
							end
						endcase
						if (acc) begin
							sst_d = SL_ACKO;
						end
					end
				end
				SL_ACKO: begin
					if (fall) begin
						sbit_d = '0;
						sst_d  = (sk_q == SK_READ) ? SL_SEND : SL_RECV;
					end
				end
				SL_SEND: begin
					if (fall && sbit_q == LAST_BIT) begin
						sbit_d = '0;
						st_d.transmit_full_flag = 1'b0;
						sst_d = SL_ACKI;
					end else if (fall) begin
						sbit_d = sbit_q + 4'h1;
					end
				end
				SL_ACKI: begin
					if (rise && sda_sy[1]) begin
						sst_d = SL_IDLE;
					end else if (rise) begin
						sbit_d = BYTE_BITS;
					end else if (fall && sbit_q == BYTE_BITS) begin
						sbit_d = '0;
						con_d.clock_release = 1'b0; // [R09] [R10]
						sev_d = 1'b1;
						sst_d = SL_SEND;
					end
				end
				default: begin
					sst_d = SL_IDLE;
				end
			endcase
		end

		// Transmit write: refused while busy, else loads and may start sending
		if (BUS_WR && BUS_ADDR == REG_TRN) begin
			if (busy) begin
				st_d.write_collision_flag = 1'b1; // [R22]
			end else begin
				trn_d = BUS_WDATA[7:0];
				st_d.transmit_full_flag = 1'b1;
				if (mown_q) begin
					msh_d  = BUS_WDATA[7:0];
					mbit_d = '0;
					mph_d  = PH0;
					st_d.tx_status = 1'b1;
					mst_d  = M_TX;
				end
			end
		end

		// Control write; release only accepts a 1 while stretching is off
		if (BUS_WR && BUS_ADDR == REG_CON) begin
			rel   = con_d.clock_release;
			con_d = cw;
			con_d.rsv_a = 1'b0;
			if (!con_q.stretch_enable && !cw.clock_release) begin
				con_d.clock_release = rel; // [R10]
			end
		end

		// Disabled or halted: sequencers fall back and ownership is dropped
		if (!run) begin
			mst_d  = M_IDLE;
			sst_d  = SL_IDLE;
			mown_d = 1'b0;
		end

		// Lines are only ever pulled low; enable releases them when clear
		scl_oe_n_d = ~(run & (mdrv.scl_low | sdrv.scl_low)); // [R06] [R25]
		sda_oe_n_d = ~(run & (mdrv.sda_low | sdrv.sda_low)); // [R06] [R25]
	end

	// State registers
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			con_q         <= twc_con_t'(CON_RST);
			st_q          <= '0;
			mst_q         <= M_IDLE;
			sst_q         <= SL_IDLE;
			sk_q          <= SK_ADR1;
			brg_q         <= '0;
			hcnt_q        <= '0;
			msk_q         <= '0;
			own_q         <= '0;
			trn_q         <= '0;
			rcv_q         <= '0;
			msh_q         <= '0;
			ssh_q         <= '0;
			mph_q         <= PH0;
			mbit_q        <= '0;
			sbit_q        <= '0;
			mown_q        <= 1'b0;
			BUS_RDATA     <= '0;
			SCL_O         <= 1'b0;
			SDA_O         <= 1'b0;
			SCL_OE_N      <= 1'b1;
			SDA_OE_N      <= 1'b1;
			PINS_OWNED    <= 1'b0;
			SLEW_DISABLE  <= 1'b0;
			ALT_THRESHOLD <= 1'b0;
			MASTER_EVENT  <= 1'b0;
			SLAVE_EVENT   <= 1'b0;
		end else begin
			con_q         <= con_d;
			st_q          <= st_d;
			mst_q         <= mst_d;
			sst_q         <= sst_d;
			sk_q          <= sk_d;
			brg_q         <= brg_d;
			hcnt_q        <= hcnt_d;
			msk_q         <= msk_d;
			own_q         <= own_d;
			trn_q         <= trn_d;
			rcv_q         <= rcv_d;
			msh_q         <= msh_d;
			ssh_q         <= ssh_d;
			mph_q         <= mph_d;
			mbit_q        <= mbit_d;
			sbit_q        <= sbit_d;
			mown_q        <= mown_d;
			BUS_RDATA     <= rdat_d;
			SCL_O         <= 1'b0; // [R25]
			SDA_O         <= 1'b0; // [R25]
			SCL_OE_N      <= scl_oe_n_d;
			SDA_OE_N      <= sda_oe_n_d;
			PINS_OWNED    <= con_q.module_enable; // [R06]
			SLEW_DISABLE  <= con_q.slew_control_disable; // [R13]
			ALT_THRESHOLD <= con_q.alt_threshold_enable; // [R13]
			MASTER_EVENT  <= mev_d;
			SLAVE_EVENT   <= sev_d; // [R14]
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	a_half_reload: assert property ((mst_q != M_IDLE && tick) |=> hcnt_q == $past(brg_q)) // [R24]
		else $error("half-period timer did not reload");
	a_start_done: assert property ((mst_q == M_START && mph_q == PH1 && tick && run)
		|=> !con_q.start_sequence_start && mown_q && mst_q == M_IDLE) // [R20]
		else $error("start sequence did not finish");
	a_stop_done: assert property ((mst_q == M_STOP && mph_q == PH2 && tick && run)
		|=> !con_q.stop_sequence_start && !mown_q) // [R18]
		else $error("stop sequence did not finish");
	a_rx_done: assert property ((mst_q == M_RX && mph_q == PH1 && tick && mbit_q == LAST_BIT && run)
		|=> !con_q.master_receive_start && st_q.receive_full_flag) // [R17]
		else $error("receive enable not cleared after eighth bit");
	a_ack_level: assert property ((mst_q == M_ACK && sst_q == SL_IDLE && run)
		|=> SDA_OE_N == $past(con_q.ack_data_value)) // [R15]
		else $error("acknowledge slot level wrong");
	a_disable_rel: assert property (!con_q.module_enable |=> SCL_OE_N && SDA_OE_N) // [R06]
		else $error("lines driven while disabled");
	a_stretch_low: assert property ((run && sst_q != SL_IDLE && !con_q.clock_release)
		|=> !SCL_OE_N) // [R08]
		else $error("slave failed to stretch clock");
	a_nack_record: assert property ((mst_q == M_TX && mph_q == PH1 && tick && mbit_q == BYTE_BITS && run)
		|=> st_q.ack_received_flag == $past(sda_sy[1])) // [R21]
		else $error("acknowledge status not recorded");
	a_wcol_reject: assert property ((BUS_WR && BUS_ADDR == REG_TRN && busy)
		|=> st_q.write_collision_flag && trn_q == $past(trn_q)) // [R22]
		else $error("busy transmit write not rejected");
	a_rxfull_clear: assert property ((BUS_RD && BUS_ADDR == REG_RCV && mst_q != M_RX && sst_q != SL_RECV)
		|=> !st_q.receive_full_flag) // [R23]
		else $error("receive full flag not cleared by read");
endmodule

// file: src/twc_pkg.sv
// Constants, register layouts and state types for the two-wire bus controller
// Operation
// R01: Master clock rate is system clock over two times (reload value plus one).
// R02: Software never programs a clock rate reload value below two.
// R03: A set mask bit makes that address bit don't-care, 7-bit and 10-bit.
// R04: Masking applies only while all-address acknowledge is off.
// R05: All-address acknowledge on: every received address is acknowledged.
// R06: Enable hands both pins to the controller; clear returns them to ports.
// R07: Stop-in-idle set halts the controller while the device idles.
// R08: Slave holds the clock low while release is 0, frees it at 1; resets 1.
// R09: Stretch on: release is read/write, cleared at transmit start and receive end.
// R10: Stretch off: software may only set release; cleared at transmit start.
// R11: Stretch enable turns software and receive clock stretching on or off.
// R12: Ten-bit select makes the slave compare a 10-bit own address, else 7-bit. The code compares 7-bit when mask bit 0 is set.
// R13: Two control bits drive slew disable and alternate threshold pad outputs.
// R14: General call enable: general call address raises an event, else ignored.
// R15: Master receive acknowledge slot sends the ack data bit, 1 NACK 0 ACK.
// R16: Ack sequence bit sends ack data; hardware clears it at sequence end.
// R17: Receive bit starts a master byte read; cleared after the eighth bit.
// R18: Stop bit makes the master send Stop; cleared when Stop completes.
// R19: Restart bit makes the master send Repeated Start; cleared when done.
// R20: Start bit makes the master send Start; cleared when Start completes.
// R21: Master transmit records the slave's acknowledge level in the ack flag.
// R22: Transmit write while busy is rejected and sets the sticky collision flag.
// R23: Receive full sets on a stored byte and clears when software reads it.
// R24: Rate generator is a down-counter; each reload marks one clock half-period.
// R25: Both bus lines are only pulled low or released, never driven high.
package twc_pkg;
	// Register indices on the plain register port
	localparam int         ADDR_W   = 3;
	localparam logic [2:0] REG_CON  = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_BRG  = 3'h2;
	localparam logic [2:0] REG_MSK  = 3'h3;
	localparam logic [2:0] REG_OWN  = 3'h4;
	localparam logic [2:0] REG_TRN  = 3'h5;
	localparam logic [2:0] REG_RCV  = 3'h6;
	// Reset values, address constants and bit counts
	localparam logic [15:0] CON_RST    = 16'h1000;
	localparam logic [2:0]  LINE_IDLE  = 3'h7;
	localparam logic [4:0]  TEN_PREFIX = 5'h1e;
	localparam logic [7:0]  GEN_CALL   = 8'h00;
	localparam logic [3:0]  LAST_BIT   = 4'h7;
	localparam logic [3:0]  BYTE_BITS  = 4'h8;
	localparam int          BRG_MIN    = 2;
	// Sequence phases, one per clock half-period
	localparam logic [1:0] PH0 = 2'h0;
	localparam logic [1:0] PH1 = 2'h1;
	localparam logic [1:0] PH2 = 2'h2;
	localparam logic [1:0] PH3 = 2'h3;

	typedef struct packed {
		logic module_enable;
		logic rsv_a;
		logic stop_in_idle;
		logic clock_release;
		logic all_address_ack_enable;
		logic ten_bit_address_select;
		logic slew_control_disable;
		logic alt_threshold_enable;
		logic general_call_enable;
		logic stretch_enable;
		logic ack_data_value;
		logic ack_sequence_start;
		logic master_receive_start;
		logic stop_sequence_start;
		logic restart_sequence_start;
		logic start_sequence_start;
	} twc_con_t;

	typedef struct packed {
		logic       ack_received_flag;
		logic       tx_status;
		logic [2:0] rsv_a;
		logic       bus_collision;
		logic       gen_call_status;
		logic       addr10_status;
		logic       write_collision_flag;
		logic       overflow_flag;
		logic       data_not_addr;
		logic       stop_seen;
		logic       start_seen;
		logic       read_not_write;
		logic       receive_full_flag;
		logic       transmit_full_flag;
	} twc_stat_t;

	typedef struct packed {
		logic scl_low;
		logic sda_low;
	} twc_drive_t;

	typedef enum logic [6:0] {
		M_IDLE = 7'h01, M_START = 7'h02, M_RSTART = 7'h04, M_STOP = 7'h08,
		M_TX = 7'h10, M_RX = 7'h20, M_ACK = 7'h40
	} twc_mst_t;

	typedef enum logic [4:0] {
		SL_IDLE = 5'h01, SL_RECV = 5'h02, SL_ACKO = 5'h04, SL_SEND = 5'h08, SL_ACKI = 5'h10
	} twc_slv_t;

	typedef enum logic [3:0] {
		SK_ADR1 = 4'h1, SK_ADR2 = 4'h2, SK_DATA = 4'h4, SK_READ = 4'h8
	} twc_kind_t;
endpackage

// file: verif/twc_bus_dev.sv
// Behavioural byte-wide bus device facing the controller's master side
`timescale 1ns/1ps
module twc_bus_dev (
	// Bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	output wire logic       sda_rel,
	// Bench control and observation
	input  wire logic       rd_mode,
	input  wire logic       nack,
	input  wire logic [7:0] tx_byte,
	output      logic [7:0] got,
	output      logic       ack_seen
);
	int   cnt = 0;
	int   ph = 9;
	logic done = 0;
	// Start or restart frames a new byte; checked 1 ns late so data beside a clock fall is no Start
	always @(negedge sda) #1 if (scl) begin
		cnt = 0;
		ph = 9;
		done = 0;
	end
	// Sample data and the master's acknowledge on the rising clock
	always @(posedge scl) begin
		if (cnt < 8) got = {got[6:0], sda};
		else begin
			ack_seen = sda;
			done = rd_mode & sda; // A refused read frees the line for Stop
		end
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// Slot moves only while the clock is low, so data never changes in a high half
	always @(negedge scl) ph = cnt;
	// Pulls low or releases, never drives high; ack slot is the ninth bit
	assign sda_rel = done | (rd_mode ? (ph > 7 || tx_byte[7 - ph]) : !(ph == 8 && !nack));
endmodule

// file: verif/two_wire_master_slave_ctrl_tb.sv
// Self-checking bench: register port, master sequences, byte-wide bus device
`timescale 1ns/1ps
module two_wire_master_slave_ctrl_tb;
	import twc_pkg::*;
	// Stimulus, outputs and open-drain lines with pull-ups
	logic [2:0]  addr = 0;
	logic [15:0] wdata = 0;
	logic [15:0] rdata;
	logic [31:0] d;
	logic        clk = 0;
	logic        rst = 1;
	logic        bwr = 0;
	logic        brd = 0;
	logic        idle = 0;
	logic        rd_mode = 0;
	logic        nack = 0;
	logic        hi = 0;
	logic [7:0]  tx_byte = 0;
	logic [7:0]  got;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, owned, slew, alt, mev, sev, ack_seen;
	wire         sda_rel;
	logic        tb_scl = 1;
	logic        tb_sda = 1;
	wire         scl = (scl_oe_n | scl_o) & tb_scl;
	wire         sda = (sda_oe_n | sda_o) & sda_rel & tb_sda;
	// Counters and the reference queue of bytes sent
	int          err_count = 0;
	int          check_count = 0;
	int          brg;
	int          lowc = 0;
	int          last_low = 0;
	int          sev_n = 0;
	int          ev_exp = 0;
	logic [6:0]  o;
	logic [31:0] seed = 32'hd3773bbf;
	logic [7:0]  exp_q[$];

	always #50 clk = ~clk;

	twc_ctrl i_dut (.CLK_SYS(clk), .RST(rst), .BUS_ADDR(addr), .BUS_WDATA(wdata),
		.BUS_WR(bwr), .BUS_RD(brd), .BUS_RDATA(rdata), .IDLE_MODE(idle), .SCL_I(scl),
		.SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_N(sda_oe_n), .PINS_OWNED(owned), .SLEW_DISABLE(slew),
		.ALT_THRESHOLD(alt), .MASTER_EVENT(mev), .SLAVE_EVENT(sev));
	twc_bus_dev i_dev (.scl(scl), .sda(sda), .sda_rel(sda_rel), .rd_mode(rd_mode),
		.nack(nack), .tx_byte(tx_byte), .got(got), .ack_seen(ack_seen));

	// Low-half length of the master clock, and any attempt to drive a line high
	always @(posedge clk) begin
		if ((!scl_oe_n & scl_o) | (!sda_oe_n & sda_o)) hi <= 1;
		if (sev === 1'b1) sev_n <= sev_n + 1;
		if (!scl_oe_n) lowc <= lowc + 1;
		else begin
			if (lowc != 0) last_low <= lowc;
			lowc <= 0;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic finish_test();
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Bus cycles start and end one nanosecond after a rising edge
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		addr <= a;
		wdata <= v;
		bwr <= 1;
		@(posedge clk);
		bwr <= 0;
		#1;
	endtask

	task automatic rdm(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		addr <= a;
		brd <= 1;
		@(posedge clk);
		brd <= 0;
		#1;
		chk("register", e, rdata & m);
	endtask

	task automatic wev();
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			if (mev === 1'b1) return;
		end
		chk("sequence done", 16'h1, 16'h0);
		finish_test();
	endtask

	// Control sequence, then its self-clearing bits must read back low
	task automatic seq(input logic [15:0] c);
		wr(REG_CON, c);
		wev();
		rdm(REG_CON, 16'hffff, c & 16'hffe0);
	endtask

	task automatic tx(input logic [7:0] b, input logic k, input logic col);
		nack <= k;
		exp_q.push_back(b);
		wr(REG_TRN, {8'h00, b});
		if (col) wr(REG_TRN, {8'h00, ~b}); // A second write while busy is dropped
		wev();
		chk("byte", {8'h00, exp_q.pop_front()}, {8'h00, got});
		chk("low half", 16'(brg + 1), last_low[15:0]);
		rdm(REG_STAT, 16'h8080, {k, 7'h00, col, 7'h00});
	endtask

	// Bench master frame to the slave side: Start, address byte, ack slot, Stop
	task automatic sfr(input logic [7:0] a, input logic e);
		logic k;
		tb_sda <= 0;
		repeat (4) @(posedge clk);
		for (int i = 7; i >= -1; i--) begin
			tb_scl <= 0;
			repeat (2) @(posedge clk);
			tb_sda <= (i < 0) | a[i & 7]; // Ninth clock frees data for the ack
			repeat (4) @(posedge clk);
			tb_scl <= 1;
			repeat (4) @(posedge clk);
		end
		k = sda;
		tb_scl <= 0;
		repeat (2) @(posedge clk);
		tb_sda <= 0;
		repeat (4) @(posedge clk);
		tb_scl <= 1;
		repeat (4) @(posedge clk);
		tb_sda <= 1;
		repeat (4) @(posedge clk);
		ev_exp += e;
		chk("slave ack", {15'h0000, !e}, {15'h0000, k});
		chk("slave event", ev_exp[15:0], sev_n[15:0]);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		#1 rst = 0;
		rdm(REG_CON, 16'hffff, CON_RST);
		rdm(REG_STAT, 16'hffff, 16'h0000);
		rdm(3'h7, 16'hffff, 16'h0000);
		brg = 2 + rnd() % 6;
		wr(REG_BRG, brg[15:0]);
		rdm(REG_BRG, 16'hffff, brg[15:0]);
		d = rnd();
		wr(REG_MSK, d[15:0]);
		rdm(REG_MSK, 16'hffff, d[15:0] & 16'h03ff);
		wr(REG_CON, 16'h0000);
		rdm(REG_CON, 16'hffff, 16'h1000);
		wr(REG_CON, 16'h0040); // Stretch must be on before release takes a 0
		wr(REG_CON, 16'h0040);
		rdm(REG_CON, 16'hffff, 16'h0040);
		wr(REG_CON, 16'h1300);
		rdm(REG_CON, 16'hffff, 16'h1300);
		chk("pads", 16'h3, {13'h0, owned, slew, alt});
		idle <= 1;
		seq(16'h9001);
		d = rnd();
		tx({d[7:1], 1'b0}, 1'b0, 1'b1);
		wr(REG_STAT, 16'h0000);
		rdm(REG_STAT, 16'h0080, 16'h0000);
		tx(d[15:8], 1'b1, 1'b0);
		seq(16'h9002);
		tx({d[7:1], 1'b1}, 1'b0, 1'b0);
		rd_mode <= 1;
		tx_byte <= d[23:16];
		seq(16'h9008);
		rdm(REG_STAT, 16'h0002, 16'h0002);
		rdm(REG_RCV, 16'hffff, {8'h00, d[23:16]});
		rdm(REG_STAT, 16'h0002, 16'h0000);
		rd_mode <= 0;
		nack <= 1;
		seq(16'h9010);
		chk("ack level", 16'h0, {15'h0, ack_seen});
		seq(16'h9004);
		// Slave side: masked match, masked or refused mismatch, all-address, general call
		d = rnd();
		o = d[6:0] | 7'h01;
		wr(REG_OWN, {9'h000, o});
		wr(REG_MSK, {9'h000, d[14:8]});
		sfr({o ^ (d[14:8] & {d[22:17], 1'b0}), 1'b0}, 1'b1);
		sfr({o ^ 7'h40, 1'b0}, d[14]);
		wr(REG_CON, 16'h9800);
		sfr({o ^ 7'h40, 1'b0}, 1'b1);
		wr(REG_CON, 16'h9000);
		sfr(8'h00, 1'b0);
		wr(REG_CON, 16'h9080);
		sfr(8'h00, 1'b1);
		wr(REG_CON, 16'hb001);
		repeat (20) @(posedge clk);
		#1 chk("idle halt", 16'h7, {13'h0, owned, scl_oe_n, sda_oe_n});
		wr(REG_CON, 16'h0000);
		repeat (3) @(posedge clk);
		#1 chk("pins", 16'h0, {15'h0, owned});
		chk("drive high", 16'h0, {15'h0, hi});
		finish_test();
	end
endmodule
